// File: hw/cct_completion_tracker.sv
// Completion credit tracker: gates non-posted requests on receive-buffer completion space
// ************************************************************
// Summary of operation
// - Outstanding count starts zero, bounded by limit
// - Count up on send, down on last completion
// - Limit is min of data and header packet counts
// - Separate pending header and data counters, reset zero
// - Needs are ceiling spans; I/O write needs no data
// - Per-packet: header strictly below, data at most pool
// - Admit, send, add needs; per-packet stores needs
// - Per-packet releases stored needs after final completion
// - Per-boundary data credits equal boundary over sixteen
// - Per-boundary data need is header need times that
// - Per-boundary releases one header per boundary block
// - Crossings computed from lower address and length
// - Optional I/O policy: one credit read, none write
// - Per-data-credit: both sums strictly below pools
// - Per-data-credit: header drops per boundary block
// - Per-data-credit: data drops per sixteen-byte block
// - Data unit may be scaled to QWORD or DWORD
// - Boundary defaults to 64 bytes unless configured
// - Request size defaults to 128 bytes unless configured
// ************************************************************
`timescale 1ns/1ps
module cct_completion_tracker
	import cct_pkg::*;
#(
	parameter cct_method_t METHOD    = cct_per_packet_method,
	parameter logic        IO_POLICY = 1'b1
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [PADDR_W-1:0]  paddr,
	input  wire logic [PDATA_W-1:0]  pwdata,
	output logic                     pready,
	output logic      [PDATA_W-1:0]  prdata,
	output logic                     pslverr,
	input  wire logic                cfg_rcb,
	input  wire logic [2:0]          cfg_mrs,
	input  wire logic                req_valid,
	output logic                     req_ready,
	input  wire logic [ADDR_W-1:0]   req_addr,
	input  wire logic [SIZE_W-1:0]   req_size,
	input  wire logic [TAG_W-1:0]    req_tag,
	input  wire logic                req_io_read,
	input  wire logic                req_io_write,
	output logic                     tx_valid,
	input  wire logic                tx_ready,
	output logic      [ADDR_W-1:0]   tx_addr,
	output logic      [SIZE_W-1:0]   tx_size,
	output logic      [TAG_W-1:0]    tx_tag,
	output logic                     tx_io_read,
	output logic                     tx_io_write,
	input  wire logic                cpl_valid,
	input  wire logic [TAG_W-1:0]    cpl_tag,
	input  wire logic [LOW_W-1:0]    cpl_lower_addr,
	input  wire logic [SIZE_W-1:0]   cpl_length,
	input  wire logic                cpl_last
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic {cct_idle, cct_send} cct_phase_t;

	typedef struct packed {
		cct_phase_t         phase;
		cct_ctrl_t          ctrl;
		logic [CNT_W-1:0]   outstanding_request_count;
		logic [CNT_W-1:0]   pending_header_credits;
		logic [CNT_W-1:0]   pending_data_credits;
		logic [CNT_W-1:0]   sent;
		logic [CNT_W-1:0]   stalls;
		logic [ADDR_W-1:0]  tx_addr;
		logic [SIZE_W-1:0]  tx_size;
		logic [TAG_W-1:0]   tx_tag;
		logic               tx_io_read;
		logic               tx_io_write;
		logic [PDATA_W-1:0] prdata;
		logic               pslverr;
	} cct_top_state_t;

	cct_top_state_t s;
	cct_top_state_t next_s;

	logic             rcb_128;
	logic [LOG_W-1:0] rcb_log;
	logic [LOG_W-1:0] mrs_log;
	logic [CNT_W-1:0] header_per_request;
	logic [CNT_W-1:0] packets_by_data;
	logic [CNT_W-1:0] packets_by_header;
	logic [CNT_W-1:0] outstanding_request_limit;
	logic [CNT_W-1:0] data_credits_per_boundary;
	logic [CNT_W-1:0] req_boundary_blocks;
	logic [CNT_W-1:0] req_credit_blocks;
	logic [CNT_W-1:0] boundary_crossings;
	logic [CNT_W-1:0] credit_crossings;
	logic [CNT_W-1:0] request_header_need;
	logic [CNT_W-1:0] request_data_need;
	logic [CNT_W-1:0] add_hdr;
	logic [CNT_W-1:0] add_data;
	logic [CNT_W-1:0] sub_hdr;
	logic [CNT_W-1:0] sub_data;
	logic             admit;
	logic             accept;
	logic             release_cpl;
	logic             req_tag_busy;
	cct_entry_t       cpl_entry;
	cct_status_t      status;

	// Saturating update keeps counters from wrapping under a stray release
	function automatic logic [CNT_W-1:0] cct_update(input logic [CNT_W-1:0] cur,
		input logic [CNT_W-1:0] add, input logic [CNT_W-1:0] sub);
		logic [CNT_W-1:0] sum;
		sum = cur + add;
		cct_update = (sum > sub) ? (sum - sub) : ZERO;
	endfunction

	// ************************************************************
	// Configuration decode and limit
	// ************************************************************
	always_comb begin
		rcb_128 = s.ctrl.use_cfg_rcb & cfg_rcb;
		rcb_log = rcb_128 ? RCB_LOG_128 : RCB_LOG_64;
		// Reserved size codes fall back to the default rather than over-allocating
		if (s.ctrl.use_cfg_mrs && (cfg_mrs <= MRS_CODE_MAX)) begin
			mrs_log = MRS_LOG_BASE + LOG_W'(cfg_mrs);
		end else begin
			mrs_log = MRS_LOG_BASE;
		end
		// Both sizes are powers of two and the request size is never below the boundary
		header_per_request        = CNT_W'(ONE << (mrs_log - rcb_log));
		packets_by_data           = CNT_W'(DATA_POOL_BYTES >> mrs_log);
		packets_by_header         = CNT_W'(HEADER_POOL / header_per_request);
		outstanding_request_limit = (packets_by_data < packets_by_header) ?
			packets_by_data : packets_by_header;
		data_credits_per_boundary = CNT_W'(ONE << (rcb_log - LOG_W'(UNIT_LOG)));
	end

	cct_span u_req_span (
		.rcb_128            (rcb_128),
		.addr_low           (req_addr[LOW_W-1:0]),
		.length             (req_size),
		.boundary_crossings (req_boundary_blocks),
		.credit_crossings   (req_credit_blocks)
	);

	cct_span u_cpl_span (
		.rcb_128            (rcb_128),
		.addr_low           (cpl_lower_addr),
		.length             (cpl_length),
		.boundary_crossings (boundary_crossings),
		.credit_crossings   (credit_crossings)
	);

	cct_tag_store u_tags (
		.pclk         (pclk),
		.presetn      (presetn),
		.wr_en        (accept),
		.wr_tag       (req_tag),
		.wr_io        (req_io_read | req_io_write),
		.wr_hdr       (request_header_need),
		.wr_data      (request_data_need),
		.free_en      (release_cpl & cpl_last),
		.free_tag     (cpl_tag),
		.req_tag      (req_tag),
		.req_tag_busy (req_tag_busy),
		.cpl_tag      (cpl_tag),
		.cpl_entry    (cpl_entry)
	);

	// ************************************************************
	// Needs and admission
	// ************************************************************
	always_comb begin
		request_header_need = req_boundary_blocks;
		if (req_io_write) begin
			request_data_need = ZERO;
		end else if (METHOD == cct_per_boundary_method && IO_POLICY && req_io_read) begin
			request_data_need = IO_READ_UNITS;
		end else if (METHOD == cct_per_boundary_method) begin
			request_data_need = CNT_W'(req_boundary_blocks * data_credits_per_boundary);
		end else begin
			request_data_need = req_credit_blocks;
		end
		unique case (METHOD)
			cct_request_limit_method: begin
				admit = s.outstanding_request_count < outstanding_request_limit;
			end
			cct_per_data_credit_method: begin
				admit = (s.pending_header_credits + request_header_need < HEADER_POOL) &&
					(s.pending_data_credits + request_data_need < DATA_POOL_UNITS);
			end
			default: begin
				admit = (s.pending_header_credits + request_header_need < HEADER_POOL) &&
					(s.pending_data_credits + request_data_need <= DATA_POOL_UNITS);
			end
		endcase
		req_ready = (s.phase == cct_idle) && s.ctrl.enable && !req_tag_busy && admit;
		accept    = req_valid && req_ready;
		// Completions for a tag that is not outstanding are ignored
		release_cpl = cpl_valid && cpl_entry.used;
	end

	// ************************************************************
	// Credit release per method
	// ************************************************************
	always_comb begin
		add_hdr  = accept ? request_header_need : ZERO;
		add_data = accept ? request_data_need : ZERO;
		sub_hdr  = ZERO;
		sub_data = ZERO;
		unique case (METHOD)
			cct_request_limit_method: begin
				add_hdr  = ZERO;
				add_data = ZERO;
			end
			cct_per_packet_method: begin
				if (release_cpl && cpl_last) begin
					sub_hdr  = cpl_entry.hdr;
					sub_data = cpl_entry.data;
				end
			end
			cct_per_boundary_method: begin
				if (release_cpl && IO_POLICY && cpl_entry.io) begin
					if (cpl_last) begin
						sub_hdr  = cpl_entry.hdr;
						sub_data = cpl_entry.data;
					end
				end else if (release_cpl) begin
					sub_hdr  = boundary_crossings;
					sub_data = CNT_W'(boundary_crossings * data_credits_per_boundary);
				end
			end
			cct_per_data_credit_method: begin
				if (release_cpl) begin
					sub_hdr  = boundary_crossings;
					sub_data = credit_crossings;
				end
			end
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.pending_header_credits = cct_update(s.pending_header_credits, add_hdr, sub_hdr);
		next_s.pending_data_credits   = cct_update(s.pending_data_credits, add_data, sub_data);
		if (METHOD == cct_request_limit_method) begin
			next_s.outstanding_request_count = cct_update(s.outstanding_request_count,
				accept ? ONE : ZERO, (release_cpl && cpl_last) ? ONE : ZERO);
		end
		if (req_valid && !req_ready) begin
			next_s.stalls = s.stalls + ONE;
		end
		unique case (s.phase)
			cct_idle: begin
				if (accept) begin
					next_s.phase       = cct_send;
					next_s.tx_addr     = req_addr;
					next_s.tx_size     = req_size;
					next_s.tx_tag      = req_tag;
					next_s.tx_io_read  = req_io_read;
					next_s.tx_io_write = req_io_write;
				end
			end
			cct_send: begin
				if (tx_ready) begin
					next_s.phase = cct_idle;
					next_s.sent  = s.sent + ONE;
				end
			end
		endcase
		// Read data is latched in the setup cycle so the access cycle answers at once
		if (psel && !penable) begin
			next_s.pslverr = 1'b0;
			unique case (paddr)
				REG_CTRL:        next_s.prdata = s.ctrl;
				REG_STATUS:      next_s.prdata = status;
				REG_PEND_HDR:    next_s.prdata = PDATA_W'(s.pending_header_credits);
				REG_PEND_DATA:   next_s.prdata = PDATA_W'(s.pending_data_credits);
				REG_OUTSTANDING: next_s.prdata = PDATA_W'(s.outstanding_request_count);
				REG_LIMIT:       next_s.prdata = PDATA_W'(outstanding_request_limit);
				REG_SENT:        next_s.prdata = PDATA_W'(s.sent);
				REG_STALLS:      next_s.prdata = PDATA_W'(s.stalls);
				default: begin
					next_s.prdata  = '0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite && paddr == REG_CTRL) begin
			next_s.ctrl      = pwdata;
			next_s.ctrl.zero = '0;
		end
	end

	always_comb begin
		status         = '0;
		status.method  = METHOD;
		status.busy    = (s.phase == cct_send);
		status.rcb_log = rcb_log;
		status.mrs_log = mrs_log;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s       <= '0;
			s.phase <= cct_idle;
			s.ctrl  <= CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign pready      = 1'b1;
	assign prdata      = s.prdata;
	assign pslverr     = s.pslverr;
	assign tx_valid    = (s.phase == cct_send);
	assign tx_addr     = s.tx_addr;
	assign tx_size     = s.tx_size;
	assign tx_tag      = s.tx_tag;
	assign tx_io_read  = s.tx_io_read;
	assign tx_io_write = s.tx_io_write;

endmodule

// File: hw/cct_span.sv
// Ceiling block counts of an address span against the boundary and the data unit
`timescale 1ns/1ps
module cct_span
	import cct_pkg::*;
(
	input  wire logic              rcb_128,
	input  wire logic [LOW_W-1:0]  addr_low,
	input  wire logic [SIZE_W-1:0] length,
	output logic      [CNT_W-1:0]  boundary_crossings,
	output logic      [CNT_W-1:0]  credit_crossings
);

	logic [SUM_W-1:0] rcb_mask;
	logic [SUM_W-1:0] rcb_sum;
	logic [SUM_W-1:0] unit_sum;

	// Adding the mask before the shift turns the floor into a ceiling
	always_comb begin
		rcb_mask           = rcb_128 ? RCB_MASK_128 : RCB_MASK_64;
		rcb_sum            = (SUM_W'(addr_low) & rcb_mask) + SUM_W'(length) + rcb_mask;
		unit_sum           = (SUM_W'(addr_low) & UNIT_MASK) + SUM_W'(length) + UNIT_MASK;
		boundary_crossings = rcb_128 ? CNT_W'(rcb_sum >> RCB_LOG_128) : CNT_W'(rcb_sum >> RCB_LOG_64);
		// A completion without data still frees one header
		boundary_crossings = (boundary_crossings == ZERO) ? ONE : boundary_crossings;
		credit_crossings   = CNT_W'(unit_sum >> UNIT_LOG);
	end

endmodule

// File: hw/cct_tag_store.sv
// Per-tag record of outstanding requests: in-use flag, I/O flag and stored needs
`timescale 1ns/1ps
module cct_tag_store
	import cct_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             wr_en,
	input  wire logic [TAG_W-1:0] wr_tag,
	input  wire logic             wr_io,
	input  wire logic [CNT_W-1:0] wr_hdr,
	input  wire logic [CNT_W-1:0] wr_data,
	input  wire logic             free_en,
	input  wire logic [TAG_W-1:0] free_tag,
	input  wire logic [TAG_W-1:0] req_tag,
	output logic                  req_tag_busy,
	input  wire logic [TAG_W-1:0] cpl_tag,
	output cct_entry_t            cpl_entry
);

	typedef struct packed {
		cct_entry_t [TAG_COUNT-1:0] entry;
	} cct_store_state_t;

	cct_store_state_t s;
	cct_store_state_t next_s;

	always_comb begin
		next_s = s;
		if (free_en) begin
			next_s.entry[free_tag].used = 1'b0;
		end
		// Admission never picks a busy tag, so a write never meets a free of the same tag
		if (wr_en) begin
			next_s.entry[wr_tag] = '{used: 1'b1, io: wr_io, hdr: wr_hdr, data: wr_data};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign req_tag_busy = s.entry[req_tag].used;
	assign cpl_entry    = s.entry[cpl_tag];

endmodule

// File: shared/cct_pkg.sv
// Shared constants, register map and types for the completion credit tracker
package cct_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int CNT_W     = 16;
	localparam int ADDR_W    = 64;
	localparam int SIZE_W    = 13;
	localparam int LOW_W     = 7;
	localparam int SUM_W     = 14;
	localparam int TAG_W     = 5;
	localparam int TAG_COUNT = 32;
	localparam int PADDR_W   = 8;
	localparam int PDATA_W   = 32;
	localparam int LOG_W     = 4;

	// ************************************************************
	// Credit pools and granularity
	// ************************************************************
	// Data unit log2 in bytes: 4 is one 16-byte credit, 3 counts QWORDs, 2 counts DWORDs
	localparam int               UNIT_LOG        = 4;
	localparam int               CREDIT_LOG      = 4;
	localparam logic [CNT_W-1:0] HEADER_POOL     = 16'h0040;
	localparam logic [CNT_W-1:0] DATA_POOL_BYTES = 16'h3E00;
	localparam logic [CNT_W-1:0] DATA_POOL_UNITS = CNT_W'(DATA_POOL_BYTES >> UNIT_LOG);
	localparam logic [CNT_W-1:0] IO_READ_UNITS   = CNT_W'(1 << (CREDIT_LOG - UNIT_LOG));
	localparam logic [CNT_W-1:0] ONE             = 16'h0001;
	localparam logic [CNT_W-1:0] ZERO            = 16'h0000;

	// ************************************************************
	// Completion boundary and request size decoding
	// ************************************************************
	localparam logic [LOG_W-1:0] RCB_LOG_64   = 4'h6;
	localparam logic [LOG_W-1:0] RCB_LOG_128  = 4'h7;
	localparam logic [SUM_W-1:0] RCB_MASK_64  = 14'h003F;
	localparam logic [SUM_W-1:0] RCB_MASK_128 = 14'h007F;
	localparam logic [SUM_W-1:0] UNIT_MASK    = SUM_W'((1 << UNIT_LOG) - 1);
	localparam logic [LOG_W-1:0] MRS_LOG_BASE = 4'h7;
	localparam logic [2:0]       MRS_CODE_MAX = 3'h5;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [PADDR_W-1:0] REG_CTRL        = 8'h00;
	localparam logic [PADDR_W-1:0] REG_STATUS      = 8'h04;
	localparam logic [PADDR_W-1:0] REG_PEND_HDR    = 8'h08;
	localparam logic [PADDR_W-1:0] REG_PEND_DATA   = 8'h0C;
	localparam logic [PADDR_W-1:0] REG_OUTSTANDING = 8'h10;
	localparam logic [PADDR_W-1:0] REG_LIMIT       = 8'h14;
	localparam logic [PADDR_W-1:0] REG_SENT        = 8'h18;
	localparam logic [PADDR_W-1:0] REG_STALLS      = 8'h1C;

	typedef struct packed {
		logic [28:0] zero;
		logic        use_cfg_mrs;
		logic        use_cfg_rcb;
		logic        enable;
	} cct_ctrl_t;

	localparam cct_ctrl_t CTRL_RESET = 32'h00000001;

	typedef struct packed {
		logic [19:0]      zero;
		logic [LOG_W-1:0] mrs_log;
		logic [LOG_W-1:0] rcb_log;
		logic             zero_b;
		logic             busy;
		logic [1:0]       method;
	} cct_status_t;

	// ************************************************************
	// Methods and per-tag record
	// ************************************************************
	typedef enum logic [1:0] {
		cct_request_limit_method,
		cct_per_packet_method,
		cct_per_boundary_method,
		cct_per_data_credit_method
	} cct_method_t;

	typedef struct packed {
		logic             used;
		logic             io;
		logic [CNT_W-1:0] hdr;
		logic [CNT_W-1:0] data;
	} cct_entry_t;

endpackage

// File: testbench/cct_core_model.sv
// Behavioural model of the core's transmit stream and completion receive stream
`timescale 1ns/1ps
module cct_core_model
	import cct_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              hold,
	input  wire logic              rcb_big,
	input  wire logic [3:0]        slow,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic [ADDR_W-1:0] tx_addr,
	input  wire logic [SIZE_W-1:0] tx_size,
	input  wire logic [TAG_W-1:0]  tx_tag,
	input  wire logic              tx_io_write,
	output logic                   cpl_valid,
	output logic [TAG_W-1:0]       cpl_tag,
	output logic [LOW_W-1:0]       cpl_lower_addr,
	output logic [SIZE_W-1:0]      cpl_length,
	output logic                   cpl_last
);
	logic [25:0] q[$];
	logic [25:0] ent;
	logic [3:0]  wait_cnt;
	int          a;
	int          rem;
	int          n;
	int          rb;

	// Transmit side may stall for a programmable number of cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (tx_valid && tx_ready) begin
			q.push_back({tx_io_write, tx_tag, tx_addr[LOW_W-1:0], tx_size});
			tx_ready <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (tx_valid) begin
			tx_ready <= wait_cnt >= slow;
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// ********************
	// Completions split at every boundary; fields scrambled when idle
	// ********************
	initial begin
		cpl_valid <= 1'b0;
		cpl_tag <= 5'h00;
		cpl_lower_addr <= 7'h00;
		cpl_length <= 13'h0000;
		cpl_last <= 1'b0;
		forever begin
			@(posedge pclk);
			if (!hold && q.size() > 0) begin
				ent = q.pop_front();
				a = int'(ent[19:13]);
				rem = ent[25] ? 0 : int'(ent[12:0]);
				rb = rcb_big ? 128 : 64;
				do begin
					n = rb - a % rb;
					if (n > rem)
						n = rem;
					cpl_valid <= 1'b1;
					cpl_tag <= ent[24:20];
					cpl_lower_addr <= 7'(a);
					cpl_length <= 13'(n);
					cpl_last <= n == rem;
					@(posedge pclk);
					a += n;
					rem -= n;
				end while (rem > 0);
				cpl_valid <= 1'b0;
				cpl_tag <= ~ent[24:20];
				cpl_lower_addr <= ~7'(a);
				cpl_length <= ~cpl_length;
				cpl_last <= 1'b0;
			end
		end
	end
endmodule

// File: testbench/cct_tracker_chk.sv
// Port-level assertions for the completion credit tracker
`timescale 1ns/1ps
module cct_tracker_chk
	import cct_pkg::*;
#(
	parameter cct_method_t METHOD = cct_per_packet_method
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic               pready,
	input wire logic [PDATA_W-1:0] prdata,
	input wire logic               pslverr,
	input wire logic               req_valid,
	input wire logic               req_ready,
	input wire logic [SIZE_W-1:0]  req_size,
	input wire logic [TAG_W-1:0]   req_tag,
	input wire logic               tx_valid,
	input wire logic               tx_ready,
	input wire logic [ADDR_W-1:0]  tx_addr,
	input wire logic [SIZE_W-1:0]  tx_size,
	input wire logic [TAG_W-1:0]   tx_tag,
	input wire logic               cpl_valid,
	input wire logic [TAG_W-1:0]   cpl_tag,
	input wire logic               cpl_last
);
	logic [TAG_COUNT-1:0] tags_out;
	wire                  accept = req_valid && req_ready;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Tags whose final completion is still due; a reused tag would corrupt stored needs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tags_out <= '0;
		else
			tags_out <= (tags_out | (accept ? TAG_COUNT'(1) << req_tag : '0))
				& ~(cpl_valid && cpl_last ? TAG_COUNT'(1) << cpl_tag : '0);
	end

	AST_TX_LAUNCH: assert property (accept |=> tx_valid && tx_tag == $past(req_tag)
		&& tx_size == $past(req_size)) else $error("request not launched with its fields");
	AST_TX_CAUSE: assert property ($rose(tx_valid) |-> $past(accept))
		else $error("transmit raised without an accepted request");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_addr)
		&& $stable(tx_tag)) else $error("transmit request changed before handshake");
	AST_TX_DONE: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("transmit request stayed after handshake");
	AST_BUSY_BLOCK: assert property (tx_valid |-> !req_ready)
		else $error("request taken while transmit busy");
	AST_TAG_UNIQUE: assert property (accept |-> !tags_out[req_tag])
		else $error("request accepted on a tag still outstanding");
	AST_METHOD: assert property (psel && !penable && paddr == REG_STATUS |=> prdata[1:0] == METHOD)
		else $error("status shows wrong method");
	AST_APB_READY: assert property (psel && penable |-> pready)
		else $error("access phase not answered");
	AST_UNMAPPED: assert property (psel && !penable && paddr > REG_STALLS |=> pslverr && prdata == '0)
		else $error("unmapped access not flagged");

	cover property (accept);
	cover property (req_valid && !req_ready);
	cover property (cpl_valid && cpl_last);
	cover property (psel && !penable && paddr > REG_STALLS);
endmodule

bind cct_completion_tracker cct_tracker_chk #(.METHOD(METHOD)) u_cct_tracker_chk (
	.pclk, .presetn, .psel, .penable, .paddr, .pready, .prdata, .pslverr, .req_valid, .req_ready,
	.req_size, .req_tag, .tx_valid, .tx_ready, .tx_addr, .tx_size, .tx_tag, .cpl_valid, .cpl_tag, .cpl_last
);

// File: testbench/testbench.sv
// Self-checking bench: register checks and request traffic in per-packet mode
`timescale 1ns/1ps
module testbench;
	import cct_pkg::*;

	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [PADDR_W-1:0] paddr = 8'h00;
	logic [PDATA_W-1:0] pwdata = 32'h00000000;
	logic               cfg_rcb = 1'b0;
	logic [2:0]         cfg_mrs = 3'h0;
	logic               req_valid = 1'b0;
	logic [ADDR_W-1:0]  req_addr = 64'h0;
	logic [SIZE_W-1:0]  req_size = 13'h0;
	logic [TAG_W-1:0]   req_tag = 5'h0;
	logic               req_io_write = 1'b0;
	logic               hold = 1'b1;
	logic [3:0]         slow = 4'h0;
	logic               pready, pslverr, req_ready, tx_valid, tx_ready, tx_io_write, cpl_valid, cpl_last, e;
	logic [PDATA_W-1:0] prdata, r, s0;
	logic [ADDR_W-1:0]  tx_addr;
	logic [SIZE_W-1:0]  tx_size, cpl_length;
	logic [TAG_W-1:0]   tx_tag, cpl_tag;
	logic [LOW_W-1:0]   cpl_lower_addr;
	int                 err_count = 0;
	int                 checks_done = 0;
	int                 ph, pd, h, d, n;

	always #2 pclk = ~pclk;

	cct_completion_tracker u_cct_completion_tracker (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.cfg_rcb, .cfg_mrs, .req_valid, .req_ready, .req_addr, .req_size, .req_tag, .req_io_read(1'b0),
		.req_io_write, .tx_valid, .tx_ready, .tx_addr, .tx_size, .tx_tag, .tx_io_read(), .tx_io_write,
		.cpl_valid, .cpl_tag, .cpl_lower_addr, .cpl_length, .cpl_last
	);
	cct_core_model u_cct_core_model (
		.pclk, .presetn, .hold, .rcb_big(cfg_rcb), .slow, .tx_valid, .tx_ready, .tx_addr, .tx_size,
		.tx_tag, .tx_io_write, .cpl_valid, .cpl_tag, .cpl_lower_addr, .cpl_length, .cpl_last
	);

	// ********************
	// Bus and comparison tasks
	// ********************
	task results;
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20) begin
			err_count++;
			results;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rd(input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] x);
		apb(1'b0, a, 32'h00000000);
		chk(r, x);
	endtask

	task send(input logic [63:0] a, input logic [12:0] sz, input logic [4:0] t, input logic iow, input logic ok);
		int k;
		logic acc;
		acc = 1'b0;
		req_valid <= 1'b1;
		req_addr <= a;
		req_size <= sz;
		req_tag <= t;
		req_io_write <= iow;
		for (k = 0; k < (ok ? 40 : 8) && !acc; k++) begin
			// Ready is read mid-cycle, settled before the accepting edge
			@(negedge pclk);
			acc = req_ready === 1'b1;
			@(posedge pclk);
		end
		req_valid <= 1'b0;
		@(posedge pclk);
		if (ok && !acc) begin
			err_count++;
			results;
		end
		chk({31'b0, acc}, {31'b0, ok});
	endtask

	// Offers a request, predicts admission from the pools and follows the pending totals
	task try(input int a, input int s, input int t, input logic iow, input int rb);
		logic ok;
		h = (a % rb + s + rb - 1) / rb;
		d = iow ? 0 : (a % 16 + s + 15) / 16;
		ok = (ph + h < HEADER_POOL) && (pd + d <= DATA_POOL_UNITS);
		send(64'(a), 13'(s), 5'(t), iow, ok);
		if (ok) begin
			ph += h;
			pd += d;
		end
		rd(REG_PEND_HDR, 32'(ph));
		rd(REG_PEND_DATA, 32'(pd));
	endtask

	task drain;
		int k;
		hold <= 1'b0;
		for (k = 0; k < 40; k++) begin
			apb(1'b0, REG_PEND_HDR, 32'h00000000);
			if (r === 32'h00000000)
				break;
		end
		rd(REG_PEND_HDR, 32'h00000000);
		rd(REG_PEND_DATA, 32'h00000000);
		hold <= 1'b1;
		ph = 0;
		pd = 0;
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		ph = 0;
		pd = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(REG_CTRL, 32'h00000001);
		rd(REG_STATUS, 32'h00000761);
		rd(REG_LIMIT, 32'h00000020);
		rd(REG_PEND_HDR, 32'h00000000);
		rd(REG_PEND_DATA, 32'h00000000);
		apb(1'b0, 8'h20, 32'h00000000);
		chk({31'b0, e}, 32'h00000001);
		chk(r, 32'h00000000);
		apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
		rd(REG_STATUS, 32'h00000761);
		try(124, 8, 0, 1'b0, 64);
		try(0, 64, 1, 1'b0, 64);
		try(63, 1, 2, 1'b0, 64);
		try(32, 64, 3, 1'b0, 64);
		try(15, 4, 4, 1'b1, 64);
		try(16, 4096, 5, 1'b0, 64);
		drain;
		rd(REG_SENT, 32'h00000005);
		slow <= 4'h3;
		try(0, 128, 0, 1'b0, 64);
		apb(1'b0, REG_STALLS, 32'h00000000);
		s0 = r;
		send(64'h40, 13'h4, 5'h0, 1'b0, 1'b0);
		rd(REG_STALLS, s0 + 32'h00000008);
		for (n = 1; n < 32; n++) begin
			try(0, 128, n, 1'b0, 64);
		end
		try(0, 64, 31, 1'b0, 64);
		drain;
		cfg_rcb <= 1'b1;
		cfg_mrs <= 3'h3;
		apb(1'b1, REG_CTRL, 32'h00000007);
		rd(REG_STATUS, 32'h00000A71);
		rd(REG_LIMIT, 32'h00000008);
		try(32, 64, 7, 1'b0, 128);
		cfg_mrs <= 3'h6;
		rd(REG_STATUS, 32'h00000771);
		rd(REG_LIMIT, 32'h00000040);
		drain;
		results;
	end

	initial begin
		repeat (100000) @(posedge pclk);
		err_count++;
		results;
	end
endmodule
